// ### smb_addr_match.sv
// Slave address recognition and automatic acknowledge for the two-wire port.
// Assumes one-cycle pulses from the bit engine, synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module smb_addr_match
  import smb_addr_pkg::*;
(
  // Clock, reset, enable
  input  wire  logic       clk,
  input  wire  logic       sys_rst,
  input  wire  logic       ce,
  // Register port
  input  wire  logic [7:0] sfr_addr,
  input  wire  logic       sfr_wr,
  input  wire  logic [7:0] sfr_wdata,
  input  wire  logic       sfr_rd,
  output var   logic [7:0] sfr_rdata,
  // Bit engine events
  input  wire  logic       start_det,
  input  wire  logic       stop_det,
  input  wire  logic       byte_valid,
  input  wire  logic [7:0] rx_byte,
  input  wire  logic       is_master,
  input  wire  logic       fw_ack,
  // Acknowledge decision
  output var   logic       ack_valid,
  output var   logic       ack_out,
  output var   logic       ack_hw,
  output var   logic       addr_match,
  output var   logic       rx_dir,
  // Serial interrupt flag
  input  wire  logic       si_clr,
  output var   logic       si_flag
);
  logic [7:0]  own_slave_address_q;
  logic [7:0]  address_mask_register_q;
  link_state_e state_q;
  logic        hw_ack_enable;
  logic        addr_byte;
  logic        data_byte;
  logic        addr_take;

  addr_cmp_if cmp_bus ();

  smb_addr_compare u_cmp (
    .c (cmp_bus.cmp)
  );

  assign hw_ack_enable                = address_mask_register_q[HW_ACK_BIT];
  assign cmp_bus.own_address_field    = own_slave_address_q[FIELD_MSB:FIELD_LSB];   // [R3]
  assign cmp_bus.address_compare_mask = address_mask_register_q[FIELD_MSB:FIELD_LSB]; // [R3]
  assign cmp_bus.general_call_enable  = own_slave_address_q[GC_BIT];               // [R6]
  assign cmp_bus.rx_addr              = rx_byte[FIELD_MSB:FIELD_LSB];               // [R11]

  assign addr_byte = ce && byte_valid && (state_q == ST_ADDR) && !start_det && !stop_det;
  assign data_byte = ce && byte_valid && (state_q == ST_DATA) && !start_det && !stop_det;
  // Unmatched addresses are dropped only when hardware decides
  assign addr_take = !hw_ack_enable || cmp_bus.hit || is_master;

  // Register writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      own_slave_address_q     <= OWN_ADDR_RST;  // [R6]
      address_mask_register_q <= ADDR_MASK_RST; // [R10]
    end else if (ce && sfr_wr) begin
      if (sfr_addr == OWN_ADDR_OFS) begin
        own_slave_address_q <= sfr_wdata; // [R6]
      end else if (sfr_addr == ADDR_MASK_OFS) begin
        address_mask_register_q <= sfr_wdata; // [R10]
      end
    end
  end

  // Register reads; unmapped addresses return zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      if (sfr_addr == OWN_ADDR_OFS) begin
        sfr_rdata <= own_slave_address_q;
      end else if (sfr_addr == ADDR_MASK_OFS) begin
        sfr_rdata <= address_mask_register_q;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // Frame tracking; a repeated START restarts the address phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (start_det) state_q <= ST_ADDR;
        end
        ST_ADDR: begin
          if (stop_det) state_q <= ST_IDLE;
          else if (start_det) state_q <= ST_ADDR;
          else if (byte_valid) state_q <= addr_take ? ST_DATA : ST_IDLE;
        end
        ST_DATA: begin
          if (stop_det) state_q <= ST_IDLE;
          else if (start_det) state_q <= ST_ADDR;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Acknowledge decision, one cycle after the byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_valid <= 1'b0;
      ack_out   <= 1'b0;
      ack_hw    <= 1'b0;
    end else if (ce) begin
      ack_valid <= addr_byte || data_byte;
      if (addr_byte) begin
        ack_hw  <= hw_ack_enable;
        ack_out <= hw_ack_enable ? cmp_bus.hit : fw_ack; // [R1] [R9]
      end else if (data_byte) begin
        ack_hw  <= hw_ack_enable;
        ack_out <= hw_ack_enable ? 1'b1 : fw_ack; // [R2] [R9]
      end
    end
  end

  // Match status and direction held for the frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_match <= 1'b0;
      rx_dir     <= 1'b0;
    end else if (ce) begin
      if (start_det || stop_det) begin
        addr_match <= 1'b0;
      end else if (addr_byte) begin
        addr_match <= cmp_bus.hit; // [R1]
        rx_dir     <= rx_byte[DIR_BIT]; // [R11]
      end
    end
  end

  // Interrupt flag; a set in the clearing cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      si_flag <= 1'b0;
    end else if (ce) begin
      if ((addr_byte && addr_take) || data_byte || stop_det) begin
        si_flag <= 1'b1; // [R7] [R8]
      end else if (si_clr) begin
        si_flag <= 1'b0;
      end
    end
  end

  // Checks
  a_hw_addr_ack: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    addr_byte && hw_ack_enable && cmp_bus.hit |=> ack_valid && ack_out && ack_hw)
    else $error("matching address not acknowledged by hardware");
  a_data_auto_ack: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    data_byte && hw_ack_enable |=> ack_valid && ack_out)
    else $error("data byte not acknowledged automatically");
  a_master_keeps: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
    addr_byte && hw_ack_enable && is_master |=> state_q == ST_DATA && si_flag)
    else $error("master role lost its frame after an address byte");
  // With hardware enable set, unmatched slave frames are dropped until the next START
  a_masked_miss: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    addr_byte && hw_ack_enable && !is_master && rx_byte[7:1] != GC_ADDR &&
    ((rx_byte[7:1] ^ own_slave_address_q[7:1]) & address_mask_register_q[7:1]) != 7'h00
    |=> ack_valid && !ack_out && state_q == ST_IDLE)
    else $error("masked mismatch was acknowledged");
  a_dont_care_bits: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
    addr_byte && hw_ack_enable &&
    (rx_byte[7:1] != GC_ADDR || own_slave_address_q[GC_BIT]) &&
    ((rx_byte[7:1] ^ own_slave_address_q[7:1]) & address_mask_register_q[7:1]) == 7'h00
    |=> ack_out && addr_match)
    else $error("don't-care bits blocked a match");
  a_gen_call: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    addr_byte && hw_ack_enable && rx_byte[7:1] == GC_ADDR
    |=> ack_out == $past(own_slave_address_q[GC_BIT]))
    else $error("general call answer disagrees with its enable");
  a_own_readback: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    ce && sfr_wr && sfr_addr == OWN_ADDR_OFS ##1 ce && sfr_rd && !sfr_wr && sfr_addr == OWN_ADDR_OFS
    |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("own address register readback wrong");
  a_mask_readback: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    ce && sfr_rd && sfr_addr == ADDR_MASK_OFS |=> sfr_rdata == $past(address_mask_register_q))
    else $error("mask register readback wrong");
  a_si_on_addr: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    addr_byte && !hw_ack_enable |=> si_flag)
    else $error("interrupt flag missing after address byte");
  a_si_on_stop: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
    ce && stop_det |=> si_flag && state_q == ST_IDLE)
    else $error("interrupt flag missing after STOP");
  a_match_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
    ce && (start_det || stop_det) |=> !addr_match)
    else $error("match status survived a START or STOP");
  a_fw_ack_path: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    (addr_byte || data_byte) && !hw_ack_enable |=> ack_valid && !ack_hw && ack_out == $past(fw_ack))
    else $error("acknowledge not left to firmware");
  a_ack_only_bytes: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
    ce && !addr_byte && !data_byte |=> !ack_valid)
    else $error("acknowledge decision without a byte");
  a_mask_reset: assert property (@(posedge clk) // [R10]
    $fell(sys_rst) |-> address_mask_register_q == ADDR_MASK_RST && !hw_ack_enable)
    else $error("mask register reset value wrong");
  a_dir_excluded: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    addr_byte && hw_ack_enable &&
    (rx_byte[7:1] != GC_ADDR || own_slave_address_q[GC_BIT]) &&
    ((rx_byte[7:1] ^ own_slave_address_q[7:1]) & address_mask_register_q[7:1]) == 7'h00
    |=> rx_dir == $past(rx_byte[DIR_BIT]) && ack_out)
    else $error("direction bit affected the match");

  // Scenarios the bench must reach
  c_hw_match: cover property (@(posedge clk) disable iff (sys_rst) addr_byte && hw_ack_enable && cmp_bus.hit);
  c_gen_call: cover property (@(posedge clk) disable iff (sys_rst)
    addr_byte && hw_ack_enable && rx_byte[7:1] == GC_ADDR);
  c_fw_data:  cover property (@(posedge clk) disable iff (sys_rst) data_byte && !hw_ack_enable);
  c_stop:     cover property (@(posedge clk) disable iff (sys_rst) ce && stop_det && state_q == ST_DATA);
  c_master_data: cover property (@(posedge clk) disable iff (sys_rst) data_byte && is_master);
endmodule
`default_nettype wire

// ### smb_addr_pkg.sv
// Constants, register map and state codes for the slave address matcher.
// Assumes an 8-bit special-function-register port and an external bit engine.
// Overview of operation
// [R1] Hardware enable makes the device ACK matching addresses
// [R2] Hardware enable also ACKs received data bytes
// [R3] Only upper seven bits of both registers compared
// [R4] Mask bit zero makes address bit don't-care
// [R5] General call matches only when its enable set
// [R6] Own address in bits 7:1, enable bit 0
// [R7] Interrupt flag after START plus address byte; with hardware enable set, only a match or the master role raises it
// [R8] Interrupt flag when STOP is detected
// [R9] Enable clear leaves all acknowledgement to firmware
// [R10] Mask resets to ones, hardware enable to zero
// [R11] Direction bit excluded from the match decision
package smb_addr_pkg;
  localparam logic [7:0] OWN_ADDR_OFS  = 8'hd7;
  localparam logic [7:0] ADDR_MASK_OFS = 8'he7;
  localparam logic [7:0] OWN_ADDR_RST  = 8'h00;
  localparam logic [7:0] ADDR_MASK_RST = 8'hfe;
  localparam int         FIELD_LSB     = 1;
  localparam int         FIELD_MSB     = 7;
  localparam int         GC_BIT        = 0;
  localparam int         HW_ACK_BIT    = 0;
  localparam int         DIR_BIT       = 0;
  localparam logic [6:0] GC_ADDR       = 7'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } link_state_e;
endpackage

// ### addr_cmp_if.sv
// Carrier between the matcher core and its address comparator.
// Assumes both ends share one clock; the compare path is combinational.
`timescale 1ns/10ps
`default_nettype none
interface addr_cmp_if;
  logic [6:0] own_address_field;
  logic [6:0] address_compare_mask;
  logic       general_call_enable;
  logic [6:0] rx_addr;
  logic       hit;

  modport core (output own_address_field, output address_compare_mask,
                output general_call_enable, output rx_addr, input hit);
  modport cmp  (input own_address_field, input address_compare_mask,
                input general_call_enable, input rx_addr, output hit);
endinterface
`default_nettype wire

// ### smb_addr_compare.sv
// Masked compare of a received 7-bit address against the own address.
// Assumes the direction bit has already been stripped by the caller.
`timescale 1ns/10ps
`default_nettype none
module smb_addr_compare
  import smb_addr_pkg::*;
(
  addr_cmp_if.cmp c
);
  function automatic logic masked_eq(input logic [6:0] a, input logic [6:0] b,
                                     input logic [6:0] m);
    masked_eq = (((a ^ b) & m) == 7'h00);
  endfunction

  // General call follows its enable alone, so no mask setting can open or hide it
  always_comb begin
    c.hit = masked_eq(c.rx_addr, c.own_address_field, c.address_compare_mask); // [R3] [R4]
    if (c.rx_addr == GC_ADDR) begin
      c.hit = c.general_call_enable; // [R5]
    end
  end
endmodule
`default_nettype wire

// ### smb_addr_tail.sv
`timescale 1ns/10ps

// ### smb_master_model.sv
// Bus master model: drives bit-engine event pulses toward the matcher.
// Assumes the bench clock; every event changes 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module smb_master_model (
  // Clock
  input  wire logic       clk,
  // Engine events
  output var  logic       start_det,
  output var  logic       stop_det,
  output var  logic       byte_valid,
  output var  logic [7:0] rx_byte
);
  initial begin
    start_det = 1'b0;
    stop_det = 1'b0;
    byte_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // One-cycle event; idle byte lines invert so stale data never looks valid
  task automatic ev(input logic s, input logic p, input logic v, input logic [7:0] b);
    @(posedge clk) #1;
    start_det = s;
    stop_det = p;
    byte_valid = v;
    rx_byte = v ? b : ~rx_byte;
    @(posedge clk) #1;
    start_det = 1'b0;
    stop_det = 1'b0;
    byte_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask
endmodule
`default_nettype wire

// ### tb_smbus_slave_address_matcher.sv
// Self-checking bench for the slave address matcher.
// Assumes the master model drives events; ce drops only in t_freeze and is_master rises only in t_data.
`timescale 1ns/10ps
`default_nettype none
module tb_smbus_slave_address_matcher;
  import smb_addr_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic       fw_ack = 1'b0;
  logic       ce = 1'b1;
  logic       is_master = 1'b0;
  logic       si_clr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, rx_byte;
  logic       start_det, stop_det, byte_valid, ack_valid, ack_out, ack_hw, addr_match, rx_dir, si_flag;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  smb_master_model m (.clk(clk), .start_det(start_det), .stop_det(stop_det), .byte_valid(byte_valid),
    .rx_byte(rx_byte));
  smb_addr_match dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .start_det(start_det),
    .stop_det(stop_det), .byte_valid(byte_valid), .rx_byte(rx_byte), .is_master(is_master), .fw_ack(fw_ack),
    .ack_valid(ack_valid), .ack_out(ack_out), .ack_hw(ack_hw), .addr_match(addr_match), .rx_dir(rx_dir),
    .si_clr(si_clr), .si_flag(si_flag));
  always #5 clk = ~clk;
  // Whole run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk) #1;
    sfr_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk) #1;
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
  endtask
  task automatic clr();
    @(posedge clk) #1;
    si_clr = 1'b1;
    @(posedge clk) #1;
    si_clr = 1'b0;
    chk({7'h00, si_flag}, 8'h00);
  endtask
  task automatic t_regs();
    rd_chk(8'hd7, 8'h00);
    rd_chk(8'he7, 8'hfe);
    wr(8'h00, 8'h55);
    rd_chk(8'h00, 8'h00);
    wr(8'hd7, 8'h69);
    rd_chk(8'hd7, 8'h69);
    // Write, then read back on the very next edge
    @(posedge clk) #1;
    sfr_addr = 8'hd7;
    sfr_wdata = 8'h2a;
    sfr_wr = 1'b1;
    @(posedge clk) #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b1;
    @(posedge clk) #1;
    sfr_rd = 1'b0;
    chk(sfr_rdata, 8'h2a);
  endtask
  // Own register, mask register, address byte; hit worked out below
  task automatic t_match();
    logic [23:0] t [9] = '{24'h68ff69, 24'h68ff6a, 24'h68ff01, 24'h69ff00, 24'h00ff00,
                           24'h68fd6b, 24'h68fd6c, 24'he0e7f9, 24'he0e7e2};
    logic        hit;
    foreach (t[i]) begin
      // Address zero answers to the general call enable alone
      hit = (t[i][7:1] == 7'h00) ? t[i][16] : (((t[i][7:1] ^ t[i][23:17]) & t[i][15:9]) == 7'h00);
      wr(8'hd7, t[i][23:16]);
      wr(8'he7, t[i][15:8]);
      clr();
      m.ev(1'b1, 1'b0, 1'b0, 8'h00);
      m.ev(1'b0, 1'b0, 1'b1, t[i][7:0]);
      chk({ack_valid, ack_hw, ack_out}, {2'b11, hit});
      chk({rx_dir, addr_match, si_flag}, {t[i][0], hit, hit});
      m.ev(1'b0, 1'b1, 1'b0, 8'h00);
    end
  endtask
  task automatic t_data();
    wr(8'hd7, 8'h68);
    wr(8'he7, 8'hff);
    m.ev(1'b1, 1'b0, 1'b0, 8'h00);
    m.ev(1'b0, 1'b0, 1'b1, 8'h68);
    clr();
    m.ev(1'b0, 1'b0, 1'b1, 8'h3c);
    chk({ack_valid, ack_hw, ack_out, si_flag}, 4'hf);
    clr();
    m.ev(1'b0, 1'b1, 1'b0, 8'h00);
    chk({si_flag, addr_match}, 2'b10);
    // Master role keeps an unmatched frame and still acks data
    is_master = 1'b1;
    clr();
    m.ev(1'b1, 1'b0, 1'b0, 8'h00);
    m.ev(1'b0, 1'b0, 1'b1, 8'h6b);
    chk({ack_valid, ack_out, si_flag}, 3'b101);
    m.ev(1'b0, 1'b0, 1'b1, 8'h5a);
    chk({ack_valid, ack_hw, ack_out}, 3'b111);
    m.ev(1'b0, 1'b1, 1'b0, 8'h00);
    is_master = 1'b0;
  endtask
  task automatic t_fw();
    wr(8'he7, 8'hfe);
    for (int f = 0; f < 2; f++) begin
      fw_ack = f[0];
      clr();
      m.ev(1'b1, 1'b0, 1'b0, 8'h00);
      m.ev(1'b0, 1'b0, 1'b1, 8'h6a);
      chk({ack_valid, ack_hw, ack_out, si_flag}, {2'b10, f[0], 1'b1});
      m.ev(1'b0, 1'b0, 1'b1, 8'h3c);
      chk({ack_valid, ack_hw, ack_out}, {2'b10, f[0]});
      m.ev(1'b0, 1'b1, 1'b0, 8'h00);
    end
  endtask
  // Clock enable low: writes and bus events must leave no trace
  task automatic t_freeze();
    ce = 1'b0;
    wr(8'hd7, 8'h12);
    m.ev(1'b1, 1'b0, 1'b0, 8'h00);
    m.ev(1'b0, 1'b0, 1'b1, 8'h68);
    chk({7'h00, ack_valid}, 8'h00);
    ce = 1'b1;
    rd_chk(8'hd7, 8'h68);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_regs();
    t_match();
    t_data();
    t_fw();
    t_freeze();
    give_verdict();
  end
endmodule
`default_nettype wire
